// File: shared/ctmr_pkg.sv
// Constants and types for the access routing block
package ctmr_pkg;
  localparam int unsigned ADDR_W          = 32;
  localparam int unsigned DATA_W          = 32;
  localparam logic [3:0]  CRN_CONTROL     = 4'h1;
  localparam logic [3:0]  CRN_TTB         = 4'h2;
  localparam logic [3:0]  CRN_DOMAIN      = 4'h3;
  localparam logic [3:0]  SUBREG_ZERO     = 4'h0;
  localparam logic [2:0]  OPC2_ZERO       = 3'h0;
  localparam int unsigned CTRL_MMU_BIT    = 0;
  localparam int unsigned CTRL_DATA_CACHE_BIT = 2;
  localparam int unsigned CTRL_INSTRUCTION_CACHE_BIT = 12;
  localparam int unsigned CTRL_REPL_BIT   = 14;
  localparam int unsigned TTB_LSB         = 14;
  localparam int unsigned TTB_W           = 18;
  localparam int unsigned DOMAIN_COUNT    = 16;
  localparam int unsigned DOMAIN_FIELD_W  = 2;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_WR_MASK    = 32'h0000_F387;
  localparam logic [31:0] CTRL_SBO_MASK   = 32'h0005_0078;
  localparam logic [17:0] TTB_RESET       = 18'h0_0000;
  localparam logic [31:0] DOMAIN_RESET    = 32'h0000_0000;
  localparam logic [1:0]  DOM_NO_ACCESS   = 2'h0;
  localparam logic [1:0]  DOM_CLIENT      = 2'h1;
  localparam logic [1:0]  DOM_RESERVED    = 2'h2;
  localparam logic [1:0]  DOM_MANAGER     = 2'h3;

  typedef enum logic [2:0] {
    ROUTE_AHB   = 3'h1,
    ROUTE_CACHE = 3'h2,
    ROUTE_TCM   = 3'h4
  } ctmr_route_t;
endpackage

// File: design/ctmr_access_router.sv
// Fetch and data access routing with control, table base and domain registers
`timescale 1ns/1ns
module ctmr_access_router
  import ctmr_pkg::*;
#(
  parameter int unsigned ITCM_ADDR_BITS = 14,
  parameter int unsigned DTCM_ADDR_BITS = 14
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              cp_req_i,
  input  wire logic              cp_write_i,
  input  wire logic [3:0]        cp_crn_i,
  input  wire logic [3:0]        cp_subreg_i,
  input  wire logic [2:0]        cp_opc2_i,
  input  wire logic [31:0]       cp_wdata_i,
  output logic                   cp_ack_o,
  output logic [31:0]            cp_rdata_o,
  input  wire logic              itcm_en_i,
  input  wire logic [31:0]       itcm_base_i,
  input  wire logic              dtcm_en_i,
  input  wire logic [31:0]       dtcm_base_i,
  input  wire logic              i_req_i,
  input  wire logic [31:0]       i_addr_i,
  input  wire logic [31:0]       i_xlat_addr_i,
  input  wire logic              i_page_cachable_i,
  input  wire logic [3:0]        i_domain_i,
  output logic                   i_valid_o,
  output ctmr_route_t            i_route_o,
  output logic [31:0]            i_addr_o,
  output logic                   i_cachable_o,
  output logic                   i_prot_check_o,
  output logic                   i_cache_lookup_o,
  output logic                   i_domain_fault_o,
  output logic                   i_perm_check_o,
  input  wire logic              d_req_i,
  input  wire logic              d_write_i,
  input  wire logic              d_abort_i,
  input  wire logic [31:0]       d_addr_i,
  input  wire logic [31:0]       d_xlat_addr_i,
  input  wire logic              d_page_cachable_i,
  input  wire logic              d_page_bufferable_i,
  input  wire logic [3:0]        d_domain_i,
  output logic                   d_valid_o,
  output ctmr_route_t            d_route_o,
  output logic [31:0]            d_addr_o,
  output logic                   d_cachable_o,
  output logic                   d_bufferable_o,
  output logic                   d_prot_check_o,
  output logic                   d_cache_lookup_o,
  output logic                   d_domain_fault_o,
  output logic                   d_perm_check_o,
  output logic                   d_tcm_re_o,
  output logic                   d_tcm_we_o,
  output logic                   repl_round_robin_o
);

  logic [31:0]      ctrl_reg;
  logic [TTB_W-1:0] ttb_reg;
  logic [31:0]      domain_reg;
  logic             mmu_en;
  logic             instruction_cache_en;
  logic             data_cache_en;
  logic [31:0]      i_pa;
  logic [31:0]      d_pa;
  logic             i_hit;
  logic             d_hit;
  logic [1:0]       i_field;
  logic [1:0]       d_field;
  logic             cp_sel;
  logic             cp_wr;

  function automatic ctmr_route_t route_calc(input logic cache_en, input logic mmu_on,
                                             input logic hit, input logic page_c,
                                             input logic data_side);
    ctmr_route_t r;
    if (hit) begin
      r = ROUTE_TCM;
    end else if (!cache_en) begin
      r = ROUTE_AHB;
    end else if (!mmu_on) begin
      r = data_side ? ROUTE_AHB : ROUTE_CACHE;
    end else begin
      r = page_c ? ROUTE_CACHE : ROUTE_AHB;
    end
    return r;
  endfunction

  function automatic logic tcm_hit(input logic en, input logic [31:0] addr,
                                   input logic [31:0] base, input int unsigned abits);
    logic [31:0] mask;
    mask = 32'hFFFF_FFFF << abits;
    return en && ((addr & mask) == (base & mask));
  endfunction

  function automatic logic [1:0] domain_field(input logic [31:0] dac, input logic [3:0] dom);
    return dac[{dom, 1'b0} +: DOMAIN_FIELD_W];
  endfunction

  assign mmu_en    = ctrl_reg[CTRL_MMU_BIT];
  assign instruction_cache_en = ctrl_reg[CTRL_INSTRUCTION_CACHE_BIT];
  assign data_cache_en = ctrl_reg[CTRL_DATA_CACHE_BIT];
  assign i_pa      = mmu_en ? i_xlat_addr_i : i_addr_i;
  assign d_pa      = mmu_en ? d_xlat_addr_i : d_addr_i;
  assign i_hit     = tcm_hit(itcm_en_i, i_pa, itcm_base_i, ITCM_ADDR_BITS);
  assign d_hit     = tcm_hit(dtcm_en_i, d_pa, dtcm_base_i, DTCM_ADDR_BITS);
  assign i_field   = domain_field(domain_reg, i_domain_i);
  assign d_field   = domain_field(domain_reg, d_domain_i);
  assign cp_sel    = cp_req_i && (cp_subreg_i == SUBREG_ZERO)
                     && (cp_opc2_i == OPC2_ZERO);
  assign cp_wr     = cp_sel && cp_write_i;

  // Register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg   <= CTRL_RESET;
      ttb_reg    <= TTB_RESET;
      domain_reg <= DOMAIN_RESET;
    end else if (cp_wr) begin
      if (cp_crn_i == CRN_CONTROL) begin
        ctrl_reg <= cp_wdata_i & CTRL_WR_MASK;
      end else if (cp_crn_i == CRN_TTB) begin
        ttb_reg <= cp_wdata_i[31:TTB_LSB];
      end else if (cp_crn_i == CRN_DOMAIN) begin
        domain_reg <= cp_wdata_i;
      end
    end
  end

  // Register reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_ack_o   <= 1'b0;
      cp_rdata_o <= 32'h0000_0000;
    end else begin
      cp_ack_o <= cp_req_i;
      if (cp_sel && !cp_write_i) begin
        if (cp_crn_i == CRN_CONTROL) begin
          cp_rdata_o <= ctrl_reg | CTRL_SBO_MASK;
        end else if (cp_crn_i == CRN_TTB) begin
          cp_rdata_o <= {ttb_reg, 14'h0000};
        end else if (cp_crn_i == CRN_DOMAIN) begin
          cp_rdata_o <= domain_reg;
        end else begin
          cp_rdata_o <= 32'h0000_0000;
        end
      end else begin
        cp_rdata_o <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      repl_round_robin_o <= 1'b0;
    end else begin
      repl_round_robin_o <= ctrl_reg[CTRL_REPL_BIT];
    end
  end

  // Instruction side, decided from enables as they stand at the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i_valid_o        <= 1'b0;
      i_route_o        <= ROUTE_AHB;
      i_addr_o         <= 32'h0000_0000;
      i_cachable_o     <= 1'b0;
      i_prot_check_o   <= 1'b0;
      i_cache_lookup_o <= 1'b0;
      i_domain_fault_o <= 1'b0;
      i_perm_check_o   <= 1'b0;
    end else begin
      i_valid_o <= i_req_i;
      if (i_req_i) begin
        i_route_o <= route_calc(instruction_cache_en, mmu_en, i_hit,
                                i_page_cachable_i, 1'b0);
        i_addr_o         <= i_pa;
        i_cachable_o     <= instruction_cache_en && !i_hit && (!mmu_en || i_page_cachable_i);
        i_prot_check_o   <= mmu_en;
        i_cache_lookup_o <= instruction_cache_en && !i_hit && (!mmu_en || i_page_cachable_i);
        i_domain_fault_o <= mmu_en && (i_field inside {DOM_NO_ACCESS, DOM_RESERVED});
        i_perm_check_o   <= mmu_en && (i_field == DOM_CLIENT);
      end else begin
        i_cache_lookup_o <= 1'b0;
        i_domain_fault_o <= 1'b0;
        i_perm_check_o   <= 1'b0;
      end
    end
  end

  // Data side
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d_valid_o        <= 1'b0;
      d_route_o        <= ROUTE_AHB;
      d_addr_o         <= 32'h0000_0000;
      d_cachable_o     <= 1'b0;
      d_bufferable_o   <= 1'b0;
      d_prot_check_o   <= 1'b0;
      d_cache_lookup_o <= 1'b0;
      d_domain_fault_o <= 1'b0;
      d_perm_check_o   <= 1'b0;
      d_tcm_re_o       <= 1'b0;
      d_tcm_we_o       <= 1'b0;
    end else begin
      d_valid_o <= d_req_i;
      if (d_req_i) begin
        d_route_o <= route_calc(data_cache_en, mmu_en, d_hit,
                                d_page_cachable_i, 1'b1);
        d_addr_o         <= d_pa;
        d_cachable_o     <= data_cache_en && mmu_en && !d_hit && d_page_cachable_i;
        d_bufferable_o   <= data_cache_en && mmu_en && !d_hit && d_page_bufferable_i;
        d_prot_check_o   <= mmu_en;
        d_cache_lookup_o <= data_cache_en && mmu_en && !d_hit && d_page_cachable_i;
        d_domain_fault_o <= mmu_en && (d_field inside {DOM_NO_ACCESS, DOM_RESERVED});
        d_perm_check_o   <= mmu_en && (d_field == DOM_CLIENT);
        d_tcm_re_o       <= d_hit && !d_write_i;
        d_tcm_we_o       <= d_hit && d_write_i && !d_abort_i;
      end else begin
        d_cache_lookup_o <= 1'b0;
        d_domain_fault_o <= 1'b0;
        d_perm_check_o   <= 1'b0;
        d_tcm_re_o       <= 1'b0;
        d_tcm_we_o       <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ttb_write;
    cp_wr && cp_crn_i == CRN_TTB;
  endsequence

  sequence s_ttb_read;
    cp_sel && !cp_write_i && cp_crn_i == CRN_TTB;
  endsequence

  i_ahb_only_a: assert property (
    i_req_i && !instruction_cache_en && !i_hit |=> i_route_o == ROUTE_AHB && !i_cache_lookup_o)
    else $error("fetch not sent to AHB with instruction_cache off");
  i_flat_cache_a: assert property (
    i_req_i && instruction_cache_en && !mmu_en && !i_hit
      |=> i_route_o == ROUTE_CACHE && i_cachable_o && !i_prot_check_o
          && i_addr_o == $past(i_addr_i))
    else $error("flat cached fetch wrong");
  i_mmu_xlat_a: assert property (
    i_req_i && instruction_cache_en && mmu_en && !i_hit
      |=> i_prot_check_o && i_addr_o == $past(i_xlat_addr_i)
          && i_cachable_o == $past(i_page_cachable_i))
    else $error("translated fetch wrong");
  d_ahb_only_a: assert property (
    d_req_i && !data_cache_en && !d_hit |=> d_route_o == ROUTE_AHB && !d_cache_lookup_o)
    else $error("data not sent to AHB with data_cache off");
  d_flat_nc_a: assert property (
    d_req_i && data_cache_en && !mmu_en && !d_hit
      |=> !d_cachable_o && !d_bufferable_o && d_addr_o == $past(d_addr_i))
    else $error("flat data access not noncachable");
  d_mmu_page_a: assert property (
    d_req_i && data_cache_en && mmu_en && !d_hit
      |=> d_prot_check_o && d_cachable_o == $past(d_page_cachable_i)
          && d_addr_o == $past(d_xlat_addr_i))
    else $error("translated data attributes wrong");
  tcm_priority_a: assert property (
    (i_req_i && i_hit |=> i_route_o == ROUTE_TCM && !i_cache_lookup_o))
    else $error("itcm hit not routed to tcm");
  abort_no_write_a: assert property (
    d_req_i && d_write_i && d_abort_i |=> !d_tcm_we_o)
    else $error("aborted write reached tcm");
  ttb_readback_a: assert property (
    s_ttb_write ##1 !cp_wr ##1 s_ttb_read
      |=> cp_rdata_o == {$past(cp_wdata_i[31:TTB_LSB], 3), 14'h0000})
    else $error("table base readback wrong");
  domain_fault_a: assert property (
    d_req_i && mmu_en && d_field[0] == 1'b0 |=> d_domain_fault_o && !d_perm_check_o)
    else $error("no access domain did not fault");

endmodule // ctmr_access_router

// File: tb/ctmr_core_side_model.sv
// Stand-in for the page table lookup that feeds the router
`timescale 1ns/1ns
module ctmr_core_side_model (
  input  wire logic [31:0] va_i,
  output logic      [31:0] pa_o,
  output logic             page_c_o,
  output logic             page_b_o,
  output logic      [3:0]  dom_o
);
  // Fixed remap of address bit 30
  assign pa_o     = va_i ^ 32'h4000_0000;
  assign page_c_o = va_i[5];
  assign page_b_o = va_i[6];
  assign dom_o    = {2'h0, va_i[9:8]};
endmodule // ctmr_core_side_model

// File: tb/ctmr_access_router_tb.sv
// Self-checking bench for the access routing block
`timescale 1ns/1ns
module ctmr_access_router_tb;
  import ctmr_pkg::*;
  localparam logic [31:0] DOM_VAL = 32'hC000_00E1;
  localparam logic [31:0] OFFS [4] = '{32'h10, 32'h4000_0310, 32'h0300_0120, 32'h0300_0260};
  logic        clk_i = 1'h0, rst_n_i = 1'h0;
  logic        cp_req = 1'h0, cp_write = 1'h0, itcm_en = 1'h0, dtcm_en = 1'h0;
  logic        i_req = 1'h0, d_req = 1'h0, d_write = 1'h0, d_abort = 1'h0;
  logic [3:0]  cp_crn = 4'h0, cp_subreg = 4'h0;
  logic [2:0]  cp_opc2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0, i_addr = 32'h0, d_addr = 32'h0, rd;
  logic [31:0] ibase = 32'h0001_0000, dbase = 32'h0002_0000;
  logic [31:0] i_pa, d_pa, cp_rdata, i_ao, d_ao;
  logic        i_pc, d_pc, d_pb, hit;
  logic [3:0]  i_dom, d_dom;
  logic        cp_ack, i_valid, i_cach, i_prot, i_look, i_df, i_pm;
  logic        d_valid, d_cach, d_buf, d_prot, d_look, d_df, d_pm, d_re, d_we, rr;
  ctmr_route_t i_route, d_route;
  int          fail_count = 0, cmp_count = 0;

  always #10 clk_i = ~clk_i;

  ctmr_core_side_model i_side_i (.va_i(i_addr), .pa_o(i_pa), .page_c_o(i_pc),
    .page_b_o(), .dom_o(i_dom));
  ctmr_core_side_model d_side_i (.va_i(d_addr), .pa_o(d_pa), .page_c_o(d_pc),
    .page_b_o(d_pb), .dom_o(d_dom));
  ctmr_access_router ctmr_access_router_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cp_req_i(cp_req), .cp_write_i(cp_write), .cp_crn_i(cp_crn), .cp_subreg_i(cp_subreg),
    .cp_opc2_i(cp_opc2), .cp_wdata_i(cp_wdata), .cp_ack_o(cp_ack), .cp_rdata_o(cp_rdata),
    .itcm_en_i(itcm_en), .itcm_base_i(ibase), .dtcm_en_i(dtcm_en), .dtcm_base_i(dbase),
    .i_req_i(i_req), .i_addr_i(i_addr), .i_xlat_addr_i(i_pa), .i_page_cachable_i(i_pc),
    .i_domain_i(i_dom), .i_valid_o(i_valid), .i_route_o(i_route), .i_addr_o(i_ao),
    .i_cachable_o(i_cach), .i_prot_check_o(i_prot), .i_cache_lookup_o(i_look),
    .i_domain_fault_o(i_df), .i_perm_check_o(i_pm), .d_req_i(d_req), .d_write_i(d_write),
    .d_abort_i(d_abort), .d_addr_i(d_addr), .d_xlat_addr_i(d_pa), .d_page_cachable_i(d_pc),
    .d_page_bufferable_i(d_pb), .d_domain_i(d_dom), .d_valid_o(d_valid), .d_route_o(d_route),
    .d_addr_o(d_ao), .d_cachable_o(d_cach), .d_bufferable_o(d_buf), .d_prot_check_o(d_prot),
    .d_cache_lookup_o(d_look), .d_domain_fault_o(d_df), .d_perm_check_o(d_pm),
    .d_tcm_re_o(d_re), .d_tcm_we_o(d_we), .repl_round_robin_o(rr));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cp_xfer(input logic w, input logic [3:0] crn, input logic [3:0] sub,
                         input logic [31:0] wd, output logic [31:0] r);
    @(posedge clk_i);
    cp_req   <= 1'h1;
    cp_write <= w;
    cp_crn   <= crn;
    cp_subreg <= sub;
    cp_wdata <= wd;
    @(posedge clk_i);
    cp_req <= 1'h0;
    #1;
    check(cp_ack, 1'h1);
    r = cp_rdata;
  endtask

  task automatic access(input logic [31:0] ia, input logic [31:0] da, input logic w,
                        input logic ab);
    @(posedge clk_i);
    i_req   <= 1'h1;
    d_req   <= 1'h1;
    i_addr  <= ia;
    d_addr  <= da;
    d_write <= w;
    d_abort <= ab;
    @(posedge clk_i);
    i_req <= 1'h0;
    d_req <= 1'h0;
    #1;
  endtask

  task automatic side(input logic ins, input logic [2:0] m, input logic [31:0] va,
                      input logic [31:0] xa, input logic [31:0] base, input logic pc,
                      input logic [3:0] dom, output logic h);
    logic [31:0] pa;
    logic [1:0]  fld;
    ctmr_route_t r;
    pa  = m[0] ? xa : va;
    h   = m[2] && (pa[31:14] == base[31:14]);
    fld = DOM_VAL[2*dom +: 2];
    if (h) r = ROUTE_TCM;
    else if (!m[1]) r = ROUTE_AHB;
    else if (!m[0]) r = ins ? ROUTE_CACHE : ROUTE_AHB;
    else r = pc ? ROUTE_CACHE : ROUTE_AHB;
    check(ins ? i_valid : d_valid, 1'h1);
    check(ins ? i_route : d_route, r);
    check(ins ? i_ao : d_ao, pa);
    check(ins ? i_prot : d_prot, m[0]);
    check(ins ? i_look : d_look, r == ROUTE_CACHE);
    check(ins ? i_df : d_df, m[0] && !fld[0]);
    check(ins ? i_pm : d_pm, m[0] && fld == DOM_CLIENT);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    check(i_route, ROUTE_AHB);
    cp_xfer(1'h0, CRN_CONTROL, SUBREG_ZERO, 32'h0, rd);
    check(rd, CTRL_SBO_MASK);
    cp_xfer(1'h1, CRN_TTB, SUBREG_ZERO, 32'hABCD_C000, rd);
    cp_xfer(1'h0, CRN_TTB, SUBREG_ZERO, 32'h0, rd);
    check(rd, 32'hABCD_C000);
    cp_xfer(1'h1, CRN_TTB, 4'h1, 32'h1234_4000, rd);
    @(posedge clk_i);
    cp_opc2 <= 3'h2;
    cp_xfer(1'h1, CRN_TTB, SUBREG_ZERO, 32'h5678_0000, rd);
    cp_xfer(1'h0, CRN_TTB, SUBREG_ZERO, 32'h0, rd);
    check(rd, 32'h0);
    @(posedge clk_i);
    cp_opc2 <= OPC2_ZERO;
    cp_xfer(1'h0, CRN_TTB, SUBREG_ZERO, 32'h0, rd);
    check(rd, 32'hABCD_C000);
    cp_xfer(1'h0, CRN_TTB, 4'h1, 32'h0, rd);
    check(rd, 32'h0);
    cp_xfer(1'h1, CRN_DOMAIN, SUBREG_ZERO, DOM_VAL, rd);
    cp_xfer(1'h0, CRN_DOMAIN, SUBREG_ZERO, 32'h0, rd);
    check(rd, DOM_VAL);
    check(rd[31:30], DOM_MANAGER);
    cp_xfer(1'h1, CRN_CONTROL, SUBREG_ZERO, 32'hFFFF_FFFF, rd);
    cp_xfer(1'h0, CRN_CONTROL, SUBREG_ZERO, 32'h0, rd);
    check(rd, CTRL_WR_MASK | CTRL_SBO_MASK);
    check(rr, 1'h1);
    $display("test registers done");
    for (int m = 0; m < 8; m++) begin
      cp_xfer(1'h1, CRN_CONTROL, SUBREG_ZERO, {19'h0, m[1], 9'h0, m[1], 1'h0, m[0]}, rd);
      @(posedge clk_i);
      itcm_en <= m[2];
      dtcm_en <= m[2];
      for (int k = 0; k < 4; k++) begin
        access(k < 2 ? ibase ^ OFFS[k] : OFFS[k], k < 2 ? dbase ^ OFFS[k] : OFFS[k],
               k[0], 1'h0);
        side(1'h1, m[2:0], i_addr, i_pa, ibase, i_pc, i_dom, hit);
        if (!hit && m[1]) check(i_cach, m[0] ? i_pc : 1'h1);
        side(1'h0, m[2:0], d_addr, d_pa, dbase, d_pc, d_dom, hit);
        check(d_cach, m[1] && m[0] && !hit && d_pc);
        check(d_buf, m[1] && m[0] && !hit && d_pb);
      end
    end
    check(rr, 1'h0);
    $display("test routing done");
    cp_xfer(1'h1, CRN_CONTROL, SUBREG_ZERO, 32'h0, rd);
    for (int k = 0; k < 4; k++) begin
      access(OFFS[2], dbase | 32'h40, k[0], k[1]);
      check(d_we, k[0] && !k[1]);
      check(d_re, !k[0]);
      check(d_route, ROUTE_TCM);
    end
    $display("test abort done");
    @(posedge clk_i);
    dtcm_en <= 1'h0;
    fork
      cp_xfer(1'h1, CRN_CONTROL, SUBREG_ZERO, 32'h0000_1005, rd);
      access(OFFS[2], OFFS[2], 1'h0, 1'h0);
    join
    check(d_route, ROUTE_AHB);
    check(d_prot, 1'h0);
    access(OFFS[2], OFFS[2], 1'h0, 1'h0);
    check(d_route, ROUTE_CACHE);
    $display("test sampling done");
    test_done();
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    test_done();
  end
endmodule // ctmr_access_router_tb
